// ### pitc_regs.svh
// register offsets, field positions and reset values of the port control bytes
`ifndef PITC_REGS_SVH
`define PITC_REGS_SVH

`define PITC_P1_CTRL_OFS 8'h10
`define PITC_P2_CTRL_OFS 8'h20
`define PITC_P3_CTRL_OFS 8'h30
`define PITC_P4_CTRL_OFS 8'h40
`define PITC_P5_CTRL_OFS 8'h50

`define PITC_STORM_BIT 7
`define PITC_DSCP_BIT 6
`define PITC_PCP_BIT 5
`define PITC_PRIO_HI 4
`define PITC_PRIO_LO 3
`define PITC_INS_BIT 2
`define PITC_REM_BIT 1

`define PITC_CTRL_RST 8'h00
`define PITC_CTRL_WMASK 8'hfe

`define PITC_RESP_OKAY 2'h0
`define PITC_RESP_SLVERR 2'h2

`define PITC_NPORTS 5
`define PITC_VID_W 12

`endif

// ### pitc_pkg.sv
// types shared by the port ingress priority and tag control logic
package pitc_pkg;

   typedef struct packed {
      logic storm_en;
      logic dscp_en;
      logic pcp_en;
      logic [1:0] prio;
      logic tag_ins;
      logic tag_rem;
      logic rsvd;
   } pitc_ctrl_t;

   // one ingress frame as seen by the classifiers
   typedef struct packed {
      logic vld;
      logic bcast;
      logic pcp_hit;
      logic [1:0] pcp_prio;
      logic dscp_hit;
      logic [1:0] dscp_prio;
   } pitc_ing_t;

   typedef struct packed {
      logic vld;
      logic [1:0] prio;
      logic storm_chk;
   } pitc_cls_t;

   // one frame about to leave a port
   typedef struct packed {
      logic vld;
      logic rx_tagged;
      logic [2:0] src_port;
   } pitc_egr_t;

   typedef struct packed {
      logic vld;
      logic insert;
      logic strip;
      logic [11:0] vid;
   } pitc_edit_t;

endpackage

// ### pitc_port_ctl.sv
// per-port priority classification and egress tag edit decision
`timescale 1ns/1ps
`include "pitc_regs.svh"

module pitc_port_ctl
#(
   parameter int NPORTS = `PITC_NPORTS
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // control byte of this port
   input wire pitc_pkg::pitc_ctrl_t ctrl,
   // ingress side
   input wire pitc_pkg::pitc_ing_t ing,
   output pitc_pkg::pitc_cls_t cls,
   // egress side
   input wire pitc_pkg::pitc_egr_t egr,
   input wire logic [NPORTS*`PITC_VID_W-1:0] vid_tbl,
   output pitc_pkg::pitc_edit_t edit
);
   import pitc_pkg::*;

   logic pcp_use;
   logic dscp_use;
   logic [1:0] prio_nxt;
   logic [`PITC_VID_W-1:0] vid_sel;

   assign pcp_use = ctrl.pcp_en && ing.pcp_hit;
   assign dscp_use = ctrl.dscp_en && ing.dscp_hit;

   // both classifiers merge by OR, port default only as fallback
   always_comb
   begin
      if (pcp_use && dscp_use)
         prio_nxt = ing.pcp_prio | ing.dscp_prio;
      else if (pcp_use)
         prio_nxt = ing.pcp_prio;
      else if (dscp_use)
         prio_nxt = ing.dscp_prio;
      else
         prio_nxt = ctrl.prio;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         cls <= '0;
      else
      begin
         cls.vld <= ing.vld;
         cls.prio <= ing.vld ? prio_nxt : 2'h0;
         cls.storm_chk <= ing.vld && ing.bcast && ctrl.storm_en;
      end
   end

   // out-of-range source ports give vid zero rather than wrapping
   always_comb
   begin
      vid_sel = '0;
      for (int k = 0; k < NPORTS; k++)
         if (egr.src_port == k[2:0])
            vid_sel = vid_tbl[k*`PITC_VID_W +: `PITC_VID_W];
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         edit <= '0;
      else
      begin
         edit.vld <= egr.vld;
         edit.insert <= egr.vld && ctrl.tag_ins && !egr.rx_tagged;
         edit.strip <= egr.vld && ctrl.tag_rem && egr.rx_tagged;
         edit.vid <= (egr.vld && !egr.rx_tagged) ? vid_sel : '0;
      end
   end

   AST_STORM_GATE: assert property (@(posedge core_clk) disable iff (srst)
      ing.vld |=> cls.storm_chk == $past(ctrl.storm_en && ing.bcast))
      else $error("storm check does not follow enable and broadcast");
   AST_DSCP_ONLY: assert property (@(posedge core_clk) disable iff (srst)
      ing.vld && dscp_use && !pcp_use |=> cls.vld && cls.prio == $past(ing.dscp_prio))
      else $error("dscp priority not applied");
   AST_PCP_ONLY: assert property (@(posedge core_clk) disable iff (srst)
      ing.vld && pcp_use && !dscp_use |=> cls.vld && cls.prio == $past(ing.pcp_prio))
      else $error("802.1p priority not applied");
   AST_PORT_DEFAULT: assert property (@(posedge core_clk) disable iff (srst)
      ing.vld && !(ctrl.pcp_en && ing.pcp_hit) && !(ctrl.dscp_en && ing.dscp_hit)
      |=> cls.prio == $past(ctrl.prio))
      else $error("port default priority not applied");
   AST_OR_MERGE: assert property (@(posedge core_clk) disable iff (srst)
      ing.vld && ctrl.pcp_en && ing.pcp_hit && ctrl.dscp_en && ing.dscp_hit
      |=> cls.prio == ($past(ing.pcp_prio) | $past(ing.dscp_prio)))
      else $error("merged priority is not the or of both");
   AST_INSERT_UNTAGGED: assert property (@(posedge core_clk) disable iff (srst)
      egr.vld && !egr.rx_tagged && ctrl.tag_ins |=> edit.insert && edit.vid == $past(vid_sel))
      else $error("untagged frame missed its tag");
   AST_NO_DOUBLE_TAG: assert property (@(posedge core_clk) disable iff (srst)
      egr.vld && egr.rx_tagged |=> !edit.insert)
      else $error("tagged frame given a second tag");
   AST_STRIP_TAGGED: assert property (@(posedge core_clk) disable iff (srst)
      egr.vld && egr.rx_tagged && ctrl.tag_rem |=> edit.strip)
      else $error("tag not stripped");
   AST_KEEP_UNTAGGED: assert property (@(posedge core_clk) disable iff (srst)
      egr.vld && !egr.rx_tagged && !ctrl.tag_ins |=> !edit.strip && !edit.insert)
      else $error("untagged frame was modified");

endmodule

// ### pitc_top.sv
// port control bytes behind an axi4-lite slave, driving the per-port classifiers
`timescale 1ns/1ps
`include "pitc_regs.svh"

module pitc_top
#(
   parameter int NPORTS = `PITC_NPORTS,
   parameter int ADDR_W = 8
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // ingress classification per port
   input wire pitc_pkg::pitc_ing_t [NPORTS-1:0] ing_desc,
   output pitc_pkg::pitc_cls_t [NPORTS-1:0] cls_res,
   // egress tag editing per port
   input wire pitc_pkg::pitc_egr_t [NPORTS-1:0] egr_desc,
   input wire logic [NPORTS*`PITC_VID_W-1:0] port_default_vlan_id,
   output pitc_pkg::pitc_edit_t [NPORTS-1:0] edit_res,
   // storm limiter enables
   output logic [NPORTS-1:0] storm_guard_en
);
   import pitc_pkg::*;

   localparam logic [7:0] OFS_TBL [5] = '{`PITC_P1_CTRL_OFS, `PITC_P2_CTRL_OFS,
      `PITC_P3_CTRL_OFS, `PITC_P4_CTRL_OFS, `PITC_P5_CTRL_OFS};

   pitc_ctrl_t [NPORTS-1:0] ctrl_r;

   logic aw_held_r;
   logic w_held_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic do_wr;
   logic wr_hit;
   logic [2:0] wr_idx;
   logic rd_hit;
   logic [2:0] rd_idx;

   // word decode; low two address bits ignored, upper bits must match
   function automatic logic [3:0] pitc_decode(input logic [ADDR_W-1:0] a);
      logic [3:0] res;
      res = 4'h0;
      for (int k = 0; k < NPORTS; k++)
         if (a[ADDR_W-1:2] == (ADDR_W-2)'(OFS_TBL[k][7:2]))
            res = {1'b1, k[2:0]};
      return res;
   endfunction

   assign aw_fire = awvalid && awready;
   assign w_fire = wvalid && wready;
   assign ar_fire = arvalid && arready;

   // one write at a time: no new address or data until the response is taken
   assign awready = !aw_held_r && !bvalid_r;
   assign wready = !w_held_r && !bvalid_r;
   assign arready = !rvalid_r;
   assign do_wr = aw_held_r && w_held_r && !bvalid_r;

   assign {wr_hit, wr_idx} = pitc_decode(waddr_r);
   assign {rd_hit, rd_idx} = pitc_decode(araddr);

   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   // write address capture
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         aw_held_r <= 1'b0;
         waddr_r <= '0;
      end
      else if (aw_fire)
      begin
         aw_held_r <= 1'b1;
         waddr_r <= awaddr;
      end
      else if (do_wr)
         aw_held_r <= 1'b0;
   end

   // write data capture
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         w_held_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end
      else if (w_fire)
      begin
         w_held_r <= 1'b1;
         wdata_r <= wdata;
         wstrb_r <= wstrb;
      end
      else if (do_wr)
         w_held_r <= 1'b0;
   end

   // write response
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= `PITC_RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? `PITC_RESP_OKAY : `PITC_RESP_SLVERR;
      end
      else if (bready)
         bvalid_r <= 1'b0;
   end

   // control bytes; bit 0 is not kept and reads zero
   for (genvar i = 0; i < NPORTS; i++)
   begin : g_port
      always_ff @(posedge core_clk)
      begin
         if (srst)
            ctrl_r[i] <= `PITC_CTRL_RST;
         else if (do_wr && wr_hit && wr_idx == 3'(i) && wstrb_r[0])
            ctrl_r[i] <= wdata_r[7:0] & `PITC_CTRL_WMASK;
      end

      assign storm_guard_en[i] = ctrl_r[i][`PITC_STORM_BIT];

      pitc_port_ctl #(.NPORTS(NPORTS)) u_port
      (
         .core_clk(core_clk),
         .srst(srst),
         .ctrl(ctrl_r[i]),
         .ing(ing_desc[i]),
         .cls(cls_res[i]),
         .egr(egr_desc[i]),
         .vid_tbl(port_default_vlan_id),
         .edit(edit_res[i])
      );

      AST_RESET_CLEARS: assert property (@(posedge core_clk) disable iff (srst)
         $past(srst) |-> ctrl_r[i] == `PITC_CTRL_RST)
         else $error("control byte not zero after reset");

      AST_WRITE_LANDS: assert property (@(posedge core_clk) disable iff (srst)
         do_wr && wr_hit && wr_idx == 3'(i) && wstrb_r[0]
         |=> ctrl_r[i] == ($past(wdata_r[7:0]) & `PITC_CTRL_WMASK))
         else $error("register write did not land");

      AST_HOLD_NO_WRITE: assert property (@(posedge core_clk) disable iff (srst)
         !(do_wr && wr_hit && wr_idx == 3'(i)) |=> $stable(ctrl_r[i]))
         else $error("control byte changed without a write");

      AST_STORM_PIN: assert property (@(posedge core_clk) disable iff (srst)
         do_wr && wr_hit && wr_idx == 3'(i) && wstrb_r[0]
         |=> storm_guard_en[i] == $past(wdata_r[`PITC_STORM_BIT]))
         else $error("storm guard enable does not follow its bit");

      AST_CLASS_BITS: assert property (@(posedge core_clk) disable iff (srst)
         do_wr && wr_hit && wr_idx == 3'(i) && wstrb_r[0]
         |=> ctrl_r[i].dscp_en == $past(wdata_r[`PITC_DSCP_BIT])
         && ctrl_r[i].pcp_en == $past(wdata_r[`PITC_PCP_BIT]))
         else $error("classifier enable bits not stored");

      AST_PRIO_FIELD: assert property (@(posedge core_clk) disable iff (srst)
         do_wr && wr_hit && wr_idx == 3'(i) && wstrb_r[0]
         |=> ctrl_r[i].prio == $past(wdata_r[`PITC_PRIO_HI:`PITC_PRIO_LO]))
         else $error("port priority field not stored");

      AST_TAG_BITS: assert property (@(posedge core_clk) disable iff (srst)
         do_wr && wr_hit && wr_idx == 3'(i) && wstrb_r[0]
         |=> ctrl_r[i].tag_ins == $past(wdata_r[`PITC_INS_BIT])
         && ctrl_r[i].tag_rem == $past(wdata_r[`PITC_REM_BIT]))
         else $error("tag insert or remove bit not stored");

      AST_STRB_LOW_IGNORED: assert property (@(posedge core_clk) disable iff (srst)
         do_wr && !wstrb_r[0] |=> $stable(ctrl_r[i]))
         else $error("write with low byte strobe clear changed a control byte");

      AST_READ_RETURNS: assert property (@(posedge core_clk) disable iff (srst)
         ar_fire && rd_hit && rd_idx == 3'(i)
         |=> rdata == {24'h0, $past(ctrl_r[i])})
         else $error("read data is not the addressed control byte");
   end

   // read path; data taken at the address handshake
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= `PITC_RESP_OKAY;
      end
      else if (ar_fire)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_hit ? {24'h0, ctrl_r[rd_idx]} : 32'h0;
         rresp_r <= rd_hit ? `PITC_RESP_OKAY : `PITC_RESP_SLVERR;
      end
      else if (rready)
         rvalid_r <= 1'b0;
   end

   AST_B_AFTER_BOTH: assert property (@(posedge core_clk) disable iff (srst)
      do_wr |=> bvalid && !aw_held_r && !w_held_r)
      else $error("write response not raised after address and data");
   AST_B_HOLDS: assert property (@(posedge core_clk) disable iff (srst)
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before bready");
   AST_R_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (srst)
      ar_fire |=> rvalid && rdata[31:8] == 24'h0)
      else $error("read answer late or upper bits set");
   AST_R_HOLDS: assert property (@(posedge core_clk) disable iff (srst)
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed before rready");
   AST_NO_AW_WHILE_B: assert property (@(posedge core_clk) disable iff (srst)
      bvalid |-> !awready && !wready)
      else $error("new write accepted while a response is pending");
   AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (srst)
      rvalid |-> rdata[0] == 1'b0)
      else $error("bit 0 reads non zero");

   // ready must be up on the first cycle after release, or the first request stalls
   AST_READY_AFTER_RESET: assert property (@(posedge core_clk)
      $fell(srst)
      |-> awready && wready && arready && !bvalid && !rvalid)
      else $error("bus not idle and ready after reset");

   AST_B_DROPS: assert property (@(posedge core_clk) disable iff (srst)
      bvalid && bready
      |=> !bvalid)
      else $error("write response stayed after it was taken");

   AST_R_DROPS: assert property (@(posedge core_clk) disable iff (srst)
      rvalid && rready
      |=> !rvalid)
      else $error("read answer stayed after it was taken");

   AST_BAD_WR_RESP: assert property (@(posedge core_clk) disable iff (srst)
      do_wr && !wr_hit
      |=> bresp == `PITC_RESP_SLVERR)
      else $error("unmapped write not answered with slave error");

   AST_GOOD_WR_RESP: assert property (@(posedge core_clk) disable iff (srst)
      do_wr && wr_hit
      |=> bresp == `PITC_RESP_OKAY)
      else $error("mapped write not answered okay");

   AST_BAD_RD_RESP: assert property (@(posedge core_clk) disable iff (srst)
      ar_fire && !rd_hit
      |=> rresp == `PITC_RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not answered with slave error and zero");

   AST_GOOD_RD_RESP: assert property (@(posedge core_clk) disable iff (srst)
      ar_fire && rd_hit
      |=> rresp == `PITC_RESP_OKAY)
      else $error("mapped read not answered okay");

endmodule

// ### pitc_top_tb.sv
// self-checking testbench of the port control register bank
`timescale 1ns/1ps
`include "pitc_regs.svh"

module pitc_top_tb;
   import pitc_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   pitc_ing_t [4:0] ing_desc = '0;
   pitc_egr_t [4:0] egr_desc = '0;
   pitc_cls_t [4:0] cls_res;
   pitc_edit_t [4:0] edit_res;
   logic [4:0] storm_guard_en;
   // distinct default vid per ingress port, port1 in the low bits
   logic [59:0] vid_tbl = 60'h5a43b7c19e826d1;
   int n_mismatch = 0;
   int cmp_count = 0;

   pitc_top u_pitc_top (.core_clk(core_clk), .srst(srst), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .ing_desc(ing_desc), .cls_res(cls_res), .egr_desc(egr_desc), .port_default_vlan_id(vid_tbl),
      .edit_res(edit_res), .storm_guard_en(storm_guard_en));

   initial
   begin
      forever #2 core_clk = ~core_clk;
   end

   task automatic close_out();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   // ready is combinational, so it is looked at mid-cycle and the handshake lands on the next rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ah;
      logic wh;
      logic an;
      logic wn;
      ah = 1'b0;
      wh = 1'b0;
      @(posedge core_clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      while (!(ah && wh))
      begin
         @(negedge core_clk);
         an = awvalid && awready;
         wn = wvalid && wready;
         @(posedge core_clk);
         if (an)
         begin
            awvalid <= 1'b0;
            ah = 1'b1;
         end
         if (wn)
         begin
            wvalid <= 1'b0;
            wh = 1'b1;
         end
      end
      do @(negedge core_clk); while (!bvalid);
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge core_clk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge core_clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(negedge core_clk); while (!arready);
      @(posedge core_clk);
      arvalid <= 1'b0;
      do @(negedge core_clk); while (!rvalid);
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge core_clk);
      rready <= 1'b0;
   endtask

   task automatic all_zero();
      for (int k = 0; k < 5; k++)
         rd(8'((k + 1) * 16), 32'h0, `PITC_RESP_OKAY);
      chk({27'h0, storm_guard_en}, 32'h0);
   endtask

   initial
   begin
      #100000;
      n_mismatch++;
      close_out();
   end

   initial
   begin
      int p;
      int s;
      logic [7:0] c;
      logic [1:0] ep;
      logic tg;
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      all_zero();
      // bit 0 is not stored, upper bytes read zero
      wr(`PITC_P1_CTRL_OFS, 32'hffffffff, 4'hf, `PITC_RESP_OKAY);
      rd(`PITC_P1_CTRL_OFS, {24'h0, `PITC_CTRL_WMASK}, `PITC_RESP_OKAY);
      wr(`PITC_P1_CTRL_OFS, 32'h0, 4'he, `PITC_RESP_OKAY);
      rd(`PITC_P1_CTRL_OFS, 32'h000000fe, `PITC_RESP_OKAY);
      wr(8'h14, 32'h0, 4'hf, `PITC_RESP_SLVERR);
      rd(8'h60, 32'h0, `PITC_RESP_SLVERR);
      // every enable and priority code against hit and miss of both classifiers
      for (int i = 0; i < 128; i++)
      begin
         p = i % 5;
         c = {i[0], i[1], i[2], i[4:3], 3'h0};
         wr(8'((p + 1) * 16), {24'h0, c}, 4'hf, `PITC_RESP_OKAY);
         chk({31'h0, storm_guard_en[p]}, {31'h0, i[0]});
         ep = (i[2] && i[5] && i[1] && i[6]) ? 2'h3 : (i[2] && i[5]) ? 2'h1 : (i[1] && i[6]) ? 2'h2 : i[4:3];
         @(posedge core_clk);
         ing_desc[p] <= {1'b1, i[1], i[5], 2'h1, i[6], 2'h2};
         @(posedge core_clk);
         ing_desc[p] <= '0;
         @(negedge core_clk);
         chk({28'h0, cls_res[p]}, {28'h0, 1'b1, ep, i[1] && i[0]});
      end
      // egress edit on every output port for both frame kinds and every source
      for (int j = 0; j < 80; j++)
      begin
         p = j % 5;
         s = (j / 8) % 5;
         tg = j[2];
         wr(8'((p + 1) * 16), {29'h0, j[0], j[1], 1'b0}, 4'hf, `PITC_RESP_OKAY);
         @(posedge core_clk);
         egr_desc[p] <= {1'b1, tg, 3'(s)};
         @(posedge core_clk);
         egr_desc[p] <= '0;
         @(negedge core_clk);
         chk({17'h0, edit_res[p]}, {17'h0, 1'b1, j[0] && !tg, j[1] && tg, tg ? 12'h0 : vid_tbl[s*12 +: 12]});
      end
      // second reset in mid-run clears what was written
      wr(`PITC_P3_CTRL_OFS, 32'h000000fe, 4'hf, `PITC_RESP_OKAY);
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      all_zero();
      close_out();
   end
endmodule
